// File: src/sssq_edge.sv
// Purpose: rising-edge pulses for a group of level inputs
// Assumes: inputs synchronous to sys_clk
// Notes: pulse is combinational, one cycle per rising edge
`timescale 1ns/1ps
module sssq_edge #(
	parameter int N = 2
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic [N-1:0] level,
	output logic      [N-1:0] rise
);
	logic [N-1:0] prev_r; // level one cycle ago

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_bit
			// held level starts nothing after the first edge
			always_ff @(posedge sys_clk or negedge resetn) begin
				if (!resetn) begin
					prev_r[i] <= 1'b1; // no false edge at release
				end else begin
					prev_r[i] <= level[i];
				end
			end
			assign rise[i] = level[i] & ~prev_r[i];
		end
	endgenerate
endmodule

// File: src/sssq_param_mem.sv
// Purpose: stored parameter words, one read and one write port
// Assumes: single clock
// Notes: read data is registered, valid one cycle after address
`timescale 1ns/1ps
module sssq_param_mem #(
	parameter int W = 32
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         we,
	input  wire logic [5:0]   waddr,
	input  wire logic [W-1:0] wdata,
	input  wire logic [5:0]   raddr,
	output logic      [W-1:0] rdata
);
	logic [W-1:0] mem_r [sssq_pkg::PWORDS]; // parameter words

	// storage, loaded with defaults at reset
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			for (int k = 0; k < sssq_pkg::PWORDS; k++) begin
				mem_r[k] <= W'(sssq_pkg::param_default(k));
			end
		end else if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= '0;
		end else begin
			rdata <= mem_r[raddr];
		end
	end
endmodule

// File: src/sssq_pkg.sv
// Purpose: shared constants and types for the servo start/stop sequencer
// Assumes: 100 MHz sys_clk, classic Wishbone slave, 32-bit data
// Notes: parameter store holds 64 words, one per parameter number
// How it works
// - show motor-speed indicator after power-up
// - new parameters apply only after power cycle
// - parameter 0 selects absolute command system
// - parameter 1: ccw increasing, feed factor ten
// - positions scaled by gear parameters 4 over 5
// - drive enable gives ready, motor locked
// - parameter 8 dog homing, increasing, open active
// - fast speed 9 to dog, creep 10
// - parameter 11 shift, zero means none
// - homing done loads address from parameter 42
// - parameter 43 ignored in dog homing
// - auto on, tables off, fwd start homes
// - auto on, bit0 on: table 1 runs
// - enable off cuts drive, motor coasts
// - alarm cuts drive, dynamic brake
// - forced stop cuts drive, brakes, warns
// - limit off clears droop, locks, reverse allowed; code refuses table starts in both directions while either limit is off
// - table run starts on either start
package sssq_pkg;
	// register byte offsets
	localparam logic [11:0] ADR_CTRL  = 12'h000;
	localparam logic [11:0] ADR_STAT  = 12'h004;
	localparam logic [11:0] ADR_PT1   = 12'h008;
	localparam logic [11:0] ADR_CUR   = 12'h00C;
	localparam logic [11:0] ADR_PBASE = 12'h100;
	localparam int          PWORDS    = 64;
	// parameter numbers
	localparam logic [5:0]  P_CMD   = 6'h00;
	localparam logic [5:0]  P_FEED  = 6'h01;
	localparam logic [5:0]  P_NUM   = 6'h04;
	localparam logic [5:0]  P_DEN   = 6'h05;
	localparam logic [5:0]  P_HTYPE = 6'h08;
	localparam logic [5:0]  P_HSPD  = 6'h09;
	localparam logic [5:0]  P_CREEP = 6'h0A;
	localparam logic [5:0]  P_SHIFT = 6'h0B;
	localparam logic [5:0]  P_HADDR = 6'h2A;
	localparam logic [5:0]  P_HDIST = 6'h2B;
	localparam logic [3:0]  NLOAD   = 4'h9;
	// parameter values after reset
	localparam logic [31:0] DEF_FEED  = 32'h0000_0001;
	localparam logic [31:0] DEF_NUM   = 32'h0000_2000;
	localparam logic [31:0] DEF_DEN   = 32'h0000_1388;
	localparam logic [31:0] DEF_HSPD  = 32'h0000_03E8;
	localparam logic [31:0] DEF_CREEP = 32'h0000_000A;
	localparam logic        CMD_ABS   = 1'b0;
	localparam logic [1:0]  HOME_DOG  = 2'h0;
	// display and warning codes
	localparam logic [3:0]  DISP_SPEED = 4'h1;
	localparam logic [3:0]  DISP_READY = 4'h2;
	localparam logic [7:0]  WARN_NONE  = 8'h00;
	localparam logic [7:0]  WARN_ESTOP = 8'hE6;
	// live parameter set
	typedef struct packed {
		logic        incr;
		logic [1:0]  feed_scale_exponent;
		logic [31:0] gear_numerator;
		logic [31:0] gear_denominator;
		logic [1:0]  home_type;
		logic [31:0] home_speed;
		logic [31:0] creep_speed;
		logic [31:0] home_shift;
		logic [31:0] home_addr;
	} sssq_params_t;
	// command to the motion stage
	typedef struct packed {
		logic        start;
		logic        inc_dir;
		logic [31:0] speed;
		logic [31:0] pulses;
	} sssq_motion_t;
	// reset value of each stored parameter
	function automatic logic [31:0] param_default(input int n);
		unique case (n)
			1:       return DEF_FEED;
			4:       return DEF_NUM;
			5:       return DEF_DEN;
			9:       return DEF_HSPD;
			10:      return DEF_CREEP;
			default: return 32'h0000_0000;
		endcase
	endfunction
endpackage

// File: src/sssq_top.sv
// Purpose: start/stop sequencing of a positioning servo drive
// Assumes: discrete command inputs synchronous to sys_clk
// Notes: stored parameters go live only on a power-cycle reload
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module sssq_top (
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	// wishbone slave
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [11:0]           wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	output logic                       wb_ack_o,
	// command inputs
	input  wire logic                  drive_enable_in,
	input  wire logic                  fwd_start_in,
	input  wire logic                  rev_start_in,
	input  wire logic                  auto_manual_sel,
	input  wire logic                  table_sel_b0,
	input  wire logic                  table_sel_b1,
	input  wire logic                  fwd_limit_in,
	input  wire logic                  rev_limit_in,
	input  wire logic                  forced_stop_in,
	input  wire logic                  alarm_in,
	input  wire logic                  near_home_in,
	input  wire logic                  home_mark_in,
	input  wire logic                  move_done_in,
	// drive outputs
	output logic                       base_drive_on,
	output logic                       dyn_brake_on,
	output logic                       servo_locked,
	output logic                       droop_clear,
	output logic                       homed_out,
	output logic      [3:0]            display_code,
	output logic      [7:0]            estop_warning_code,
	output sssq_pkg::sssq_motion_t     motion
);
	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_FAST, ST_CREEP, ST_SHIFT, ST_RUN
	} sssq_state_t;
	// reload states
	typedef enum logic [1:0] {
		LD_IDLE, LD_READ, LD_CAP
	} sssq_load_t;

	sssq_state_t            state_r;      // motion sequence
	sssq_load_t             ld_r;         // parameter reload
	logic [3:0]             ld_step_r;    // reload index
	sssq_pkg::sssq_params_t prm_r;        // live parameters
	logic [31:0]            pt1_pos_r;    // point table 1 position
	logic [31:0]            cur_addr_r;   // current address
	logic [31:0]            tgt_addr_r;   // address being run to
	logic                   bus_ph_r;     // bus read issued
	logic                   reload_req_r; // pending power cycle
	logic [1:0]             starts;       // start edges
	logic [31:0]            mem_rd;       // stored word
	logic [5:0]             mem_ra;       // stored read address
	logic                   mem_we;       // stored write strobe
	logic                   bus_req;      // new bus access
	logic                   is_par;       // parameter window hit
	logic                   stop_brake;   // abrupt stop cause
	logic                   enabled;      // drive may run
	logic                   home_mode;    // homing selected
	logic                   pt1_mode;     // point table 1 selected
	logic                   dog_active;   // near-home sensor active
	logic                   fwd_ok;       // travel allowed upward
	logic                   rev_ok;       // travel allowed downward

	// parameter number fetched by each reload step
	function automatic logic [5:0] load_addr(input logic [3:0] s);
		unique case (s)
			4'h0:    return sssq_pkg::P_CMD;
			4'h1:    return sssq_pkg::P_FEED;
			4'h2:    return sssq_pkg::P_NUM;
			4'h3:    return sssq_pkg::P_DEN;
			4'h4:    return sssq_pkg::P_HTYPE;
			4'h5:    return sssq_pkg::P_HSPD;
			4'h6:    return sssq_pkg::P_CREEP;
			4'h7:    return sssq_pkg::P_SHIFT;
			default: return sssq_pkg::P_HADDR;
		endcase
	endfunction

	// feed length multiplier, ten to the exponent
	function automatic logic [31:0] pow10(input logic [1:0] e);
		unique case (e)
			2'h0: return 32'h0000_0001;
			2'h1: return 32'h0000_000A;
			2'h2: return 32'h0000_0064;
			2'h3: return 32'h0000_03E8;
		endcase
	endfunction

	// address units to command pulses through the gear
	function automatic logic [31:0] to_pulses(
		input logic signed [31:0] d,
		input sssq_pkg::sssq_params_t p
	);
		logic signed [95:0] num;
		logic signed [95:0] den;
		num = 96'(d) * $signed({64'h0, pow10(p.feed_scale_exponent)});
		num = num * $signed({64'h0, p.gear_numerator});
		den = $signed({64'h0, p.gear_denominator});
		if (den == 96'sh0) begin
			den = 96'sh1; // zero divisor guard
		end
		return 32'(num / den);
	endfunction

	// start edges: bit0 forward, bit1 reverse
	sssq_edge #(
		.N (2)
	) u_edge (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.level   ({rev_start_in, fwd_start_in}),
		.rise    (starts)
	);

	// stored parameters; writes wait for a reload
	sssq_param_mem #(
		.W (32)
	) u_mem (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.we      (mem_we),
		.waddr   (wb_adr_i[7:2]),
		.wdata   (wb_dat_i),
		.raddr   (mem_ra),
		.rdata   (mem_rd)
	);

	// bus decode
	assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign is_par  = (wb_adr_i[11:8] == sssq_pkg::ADR_PBASE[11:8]);
	assign mem_we  = bus_req & bus_ph_r & wb_we_i & is_par & (&wb_sel_i);
	assign mem_ra  = (ld_r != LD_IDLE) ? load_addr(ld_step_r) : wb_adr_i[7:2];

	// command input decode
	assign stop_brake = alarm_in | ~forced_stop_in;
	assign enabled    = drive_enable_in & ~stop_brake;
	assign home_mode  = auto_manual_sel & ~table_sel_b0 & ~table_sel_b1;
	assign pt1_mode   = auto_manual_sel & table_sel_b0 & ~table_sel_b1;
	assign dog_active = ~near_home_in;
	assign fwd_ok     = fwd_limit_in;
	assign rev_ok     = rev_limit_in;

	// bus handshake: address phase, then ack with data
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			bus_ph_r <= 1'b0;
			wb_ack_o <= 1'b0;
		end else if (wb_ack_o) begin
			bus_ph_r <= 1'b0;
			wb_ack_o <= 1'b0; // drop after one cycle
		end else if (bus_req && ld_r == LD_IDLE) begin
			bus_ph_r <= ~bus_ph_r;
			wb_ack_o <= bus_ph_r;
		end else begin
			bus_ph_r <= 1'b0;
			wb_ack_o <= 1'b0;
		end
	end

	// read data mux, registered with the ack
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_req && bus_ph_r && ld_r == LD_IDLE) begin
			if (is_par) begin
				wb_dat_o <= mem_rd;
			end else begin
				unique case (wb_adr_i)
					sssq_pkg::ADR_CTRL: wb_dat_o <= {31'h0, reload_req_r};
					sssq_pkg::ADR_STAT: wb_dat_o <= {16'h0, estop_warning_code,
						homed_out, servo_locked, dyn_brake_on, base_drive_on,
						1'b0, state_r};
					sssq_pkg::ADR_PT1:  wb_dat_o <= pt1_pos_r;
					sssq_pkg::ADR_CUR:  wb_dat_o <= cur_addr_r;
					default:            wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// point table 1 position, software written
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pt1_pos_r <= 32'h0000_0000;
		end else if (bus_req && bus_ph_r && wb_we_i && wb_adr_i == sssq_pkg::ADR_PT1) begin
			for (int b = 0; b < 4; b++) begin
				if (wb_sel_i[b]) begin
					pt1_pos_r[8*b +: 8] <= wb_dat_i[8*b +: 8];
				end
			end
		end
	end

	// power-cycle request; bus write sets, cleared whenever idle with drive enable off
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reload_req_r <= 1'b1; // power-up load
		end else if (bus_req && bus_ph_r && wb_we_i && wb_sel_i[0] &&
				wb_adr_i == sssq_pkg::ADR_CTRL && wb_dat_i[0]) begin
			reload_req_r <= 1'b1;
		end else if (ld_r == LD_IDLE && state_r == ST_IDLE && !drive_enable_in) begin
			reload_req_r <= 1'b0; // taken while drive is off
		end
	end

	// reload walk over stored words
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ld_r      <= LD_IDLE;
			ld_step_r <= 4'h0;
		end else begin
			unique case (ld_r)
				LD_IDLE: begin
					if (reload_req_r && state_r == ST_IDLE && !drive_enable_in &&
							!bus_ph_r) begin
						ld_r      <= LD_READ;
						ld_step_r <= 4'h0;
					end
				end
				LD_READ: ld_r <= LD_CAP;
				LD_CAP: begin
					if (ld_step_r == sssq_pkg::NLOAD - 4'h1) begin
						ld_r <= LD_IDLE;
					end else begin
						ld_r      <= LD_READ;
						ld_step_r <= ld_step_r + 4'h1;
					end
				end
			endcase
		end
	end

	// capture live parameters; parameter 43 never read
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			prm_r <= '0;
			prm_r.feed_scale_exponent <= sssq_pkg::DEF_FEED[1:0];
			prm_r.gear_numerator      <= sssq_pkg::DEF_NUM;
			prm_r.gear_denominator    <= sssq_pkg::DEF_DEN;
			prm_r.home_speed          <= sssq_pkg::DEF_HSPD;
			prm_r.creep_speed         <= sssq_pkg::DEF_CREEP;
		end else if (ld_r == LD_CAP) begin
			unique case (ld_step_r)
				4'h0: prm_r.incr <= mem_rd[0] != sssq_pkg::CMD_ABS;
				4'h1: prm_r.feed_scale_exponent <= mem_rd[1:0];
				4'h2: prm_r.gear_numerator <= mem_rd;
				4'h3: prm_r.gear_denominator <= mem_rd;
				4'h4: prm_r.home_type <= mem_rd[1:0];
				4'h5: prm_r.home_speed <= mem_rd;
				4'h6: prm_r.creep_speed <= mem_rd;
				4'h7: prm_r.home_shift <= mem_rd;
				default: prm_r.home_addr <= mem_rd;
			endcase
		end
	end

	// sequence of homing and point table runs
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_r    <= ST_IDLE;
			tgt_addr_r <= 32'h0000_0000;
		end else if (!enabled || ld_r != LD_IDLE) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (home_mode && starts[0] && fwd_ok &&
							prm_r.home_type == sssq_pkg::HOME_DOG) begin
						state_r <= ST_FAST;
					end else if (pt1_mode && (|starts) && homed_out &&
							fwd_ok && rev_ok) begin
						state_r    <= ST_RUN;
						tgt_addr_r <= prm_r.incr ?
							(starts[1] ? cur_addr_r - pt1_pos_r : cur_addr_r + pt1_pos_r)
							: pt1_pos_r;
					end
				end
				ST_FAST: begin
					if (!fwd_ok) begin
						state_r <= ST_IDLE;
					end else if (dog_active) begin
						state_r <= ST_CREEP;
					end
				end
				ST_CREEP: begin
					if (!fwd_ok) begin
						state_r <= ST_IDLE;
					end else if (home_mark_in) begin
						state_r <= (prm_r.home_shift == 32'h0) ? ST_IDLE : ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (move_done_in || !fwd_ok) begin
						state_r <= ST_IDLE;
					end
				end
				ST_RUN: begin
					if (move_done_in) begin
						state_r <= ST_IDLE;
					end else if (motion.inc_dir ? !fwd_ok : !rev_ok) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// current address and homed flag
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cur_addr_r <= 32'h0000_0000;
			homed_out  <= 1'b0;
		end else if (enabled && ld_r == LD_IDLE && ((state_r == ST_CREEP &&
				home_mark_in && prm_r.home_shift == 32'h0) ||
				(state_r == ST_SHIFT && move_done_in))) begin
			cur_addr_r <= prm_r.home_addr;
			homed_out  <= 1'b1;
		end else if (enabled && state_r == ST_RUN && move_done_in) begin
			cur_addr_r <= tgt_addr_r;
		end else if (state_r == ST_FAST) begin
			homed_out <= 1'b0; // new homing pending
		end
	end

	// command to the motion stage
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			motion <= '0;
		end else begin
			motion.start <= 1'b0;
			if (!enabled) begin
				motion.speed <= 32'h0;
			end else if (state_r == ST_IDLE && home_mode && starts[0] && fwd_ok) begin
				motion.start   <= 1'b1;
				motion.inc_dir <= 1'b1;
				motion.speed   <= prm_r.home_speed;
				motion.pulses  <= 32'h0;
			end else if (state_r == ST_FAST && dog_active) begin
				motion.speed <= prm_r.creep_speed;
			end else if (state_r == ST_CREEP && home_mark_in &&
					prm_r.home_shift != 32'h0) begin
				motion.start   <= 1'b1;
				motion.speed   <= prm_r.creep_speed;
				motion.pulses  <= to_pulses(prm_r.home_shift, prm_r);
			end else if (state_r == ST_RUN && motion.speed == 32'h0) begin
				motion.start   <= 1'b1;
				motion.inc_dir <= ($signed(tgt_addr_r) >=
					$signed(cur_addr_r));
				motion.speed   <= prm_r.home_speed;
				motion.pulses  <= to_pulses(tgt_addr_r - cur_addr_r, prm_r);
			end else if (state_r == ST_IDLE) begin
				motion.speed <= 32'h0;
			end
		end
	end

	// power stage, brake and lock
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			base_drive_on <= 1'b0;
			dyn_brake_on  <= 1'b0;
			servo_locked  <= 1'b0;
		end else begin
			base_drive_on <= enabled;
			dyn_brake_on  <= stop_brake;
			servo_locked  <= enabled && state_r == ST_IDLE;
		end
	end

	// droop clear pulse when a limit opens
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			droop_clear <= 1'b0;
		end else begin
			droop_clear <= enabled && state_r != ST_IDLE && (motion.inc_dir ?
				!fwd_ok : !rev_ok);
		end
	end

	// display and warning code
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			display_code       <= sssq_pkg::DISP_SPEED;
			estop_warning_code <= sssq_pkg::WARN_NONE;
		end else begin
			display_code <= (enabled && servo_locked) ?
				sssq_pkg::DISP_READY : sssq_pkg::DISP_SPEED;
			estop_warning_code <= forced_stop_in ?
				sssq_pkg::WARN_NONE : sssq_pkg::WARN_ESTOP;
		end
	end
endmodule

// File: tb/sssq_host_model.sv
// Purpose: host driving the discrete command inputs
// Assumes: requests come from the bench on req
// Notes: pins change only on rising edges
`timescale 1ns/1ps
module sssq_host_model (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic [12:0] req,
	output logic      [12:0] pins
);
	// power-up settle count
	logic [4:0] pwr_r;
	// enable held off until power has settled
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pwr_r <= 5'h00;
			pins  <= 13'h0074;
		end else begin
			if (pwr_r != 5'h1F) begin
				pwr_r <= pwr_r + 5'h01;
			end
			pins <= {req[12] && (pwr_r == 5'h1F), req[11:0]};
		end
	end
endmodule

// File: tb/sssq_monitor.sv
// Purpose: timing checks on the sequencer ports
// Assumes: one clock, async active-low reset
// Notes: bound into sssq_top below
`timescale 1ns/1ps
module sssq_monitor (
	input wire logic                   sys_clk,
	input wire logic                   resetn,
	input wire logic                   drive_enable_in,
	input wire logic                   fwd_start_in,
	input wire logic                   rev_start_in,
	input wire logic                   auto_manual_sel,
	input wire logic                   table_sel_b0,
	input wire logic                   table_sel_b1,
	input wire logic                   fwd_limit_in,
	input wire logic                   rev_limit_in,
	input wire logic                   forced_stop_in,
	input wire logic                   alarm_in,
	input wire logic                   base_drive_on,
	input wire logic                   dyn_brake_on,
	input wire logic                   servo_locked,
	input wire logic                   homed_out,
	input wire logic [7:0]             estop_warning_code,
	input wire sssq_pkg::sssq_motion_t motion
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// healthy: enabled, no forced stop, no alarm
	logic ok;
	assign ok = drive_enable_in && forced_stop_in && !alarm_in;
	// mode decodes
	logic hm;
	logic t1;
	assign hm = auto_manual_sel && !table_sel_b0 && !table_sel_b1;
	assign t1 = auto_manual_sel && table_sel_b0 && !table_sel_b1;
	property p_coast; !drive_enable_in |=> !base_drive_on; endproperty
	property p_alarm; alarm_in |=> dyn_brake_on && !base_drive_on; endproperty
	property p_estop; !forced_stop_in |=> estop_warning_code == 8'hE6 && dyn_brake_on; endproperty
	property p_noest; forced_stop_in |=> estop_warning_code == 8'h00; endproperty
	property p_ready; ok [*2] |=> base_drive_on; endproperty
	property p_pulse; motion.start |=> !motion.start; endproperty
	property p_home;
		$rose(fwd_start_in) && hm && fwd_limit_in && servo_locked && ok
		|=> motion.start && motion.inc_dir;
	endproperty
	property p_auto;
		$rose(rev_start_in) && t1 && fwd_limit_in && rev_limit_in && homed_out
		&& servo_locked && ok |=> !motion.start ##1 motion.start;
	endproperty
	a_coast: assert property (p_coast) else $error("drive on after enable off");
	a_alarm: assert property (p_alarm) else $error("no brake on alarm");
	a_estop: assert property (p_estop) else $error("no forced stop reaction");
	a_noest: assert property (p_noest) else $error("stray warning code");
	a_ready: assert property (p_ready) else $error("drive not on when enabled");
	a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
	a_home: assert property (p_home) else $error("homing did not start");
	a_auto: assert property (p_auto) else $error("table run did not start");
	c_home: cover property (motion.start && motion.inc_dir);
	c_brake: cover property (dyn_brake_on);
	c_estop: cover property (estop_warning_code == 8'hE6);
endmodule
bind sssq_top sssq_monitor u_mon (
	.sys_clk, .resetn, .drive_enable_in, .fwd_start_in, .rev_start_in,
	.auto_manual_sel, .table_sel_b0, .table_sel_b1, .fwd_limit_in, .rev_limit_in,
	.forced_stop_in, .alarm_in, .base_drive_on, .dyn_brake_on, .servo_locked,
	.homed_out, .estop_warning_code, .motion
);

// File: tb/tb_top.sv
// Purpose: directed bench for the sequencer
// Assumes: host model owns the command pins
// Notes: bus cycles sample ack and read data on the rising edge
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk;
	logic        resetn;
	logic        wb_cyc_i;
	logic        wb_stb_i;
	logic        wb_we_i;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i;
	logic [31:0] wb_dat_o;
	logic [31:0] q;
	logic        wb_ack_o;
	logic        base_drive_on;
	logic        dyn_brake_on;
	logic        servo_locked;
	logic        droop_clear;
	logic        homed_out;
	logic        hit;
	logic        dh;
	logic [3:0]  display_code;
	logic [7:0]  estop_warning_code;
	logic [12:0] req;
	logic [12:0] pins;
	int          n_fail;
	int          check_count;
	sssq_pkg::sssq_motion_t motion;
	localparam int EN = 12, FS = 11, RS = 10, AM = 9, B0 = 8, B1 = 7;
	localparam int FL = 6, RL = 5, ES = 4, AL = 3, NH = 2, HM = 1, MD = 0;
	// parameter numbers and their values after reset
	logic [5:0]  pn [6] = '{6'h00, 6'h01, 6'h04, 6'h05, 6'h09, 6'h0A};
	logic [31:0] pv [6] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_2000,
		32'h0000_1388, 32'h0000_03E8, 32'h0000_000A};
	sssq_host_model u_host (.sys_clk, .resetn, .req, .pins);
	sssq_top u_dut (
		.sys_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o,
		.drive_enable_in(pins[EN]), .fwd_start_in(pins[FS]), .rev_start_in(pins[RS]),
		.auto_manual_sel(pins[AM]), .table_sel_b0(pins[B0]), .table_sel_b1(pins[B1]),
		.fwd_limit_in(pins[FL]), .rev_limit_in(pins[RL]), .forced_stop_in(pins[ES]),
		.alarm_in(pins[AL]), .near_home_in(pins[NH]), .home_mark_in(pins[HM]),
		.move_done_in(pins[MD]), .base_drive_on, .dyn_brake_on, .servo_locked,
		.droop_clear, .homed_out, .display_code, .estop_warning_code, .motion
	);
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic conclude;
		$display("checks %0d fails %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", nm, e, g);
			n_fail++;
		end
	endtask
	// one classic cycle, held until ack
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
		i = 0;
		do begin
			@(posedge sys_clk);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 200);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (i >= 200) begin
			n_fail++;
			conclude();
		end
	endtask
	task automatic pin(input int b, input logic v);
		@(posedge sys_clk);
		req[b] <= v;
	endtask
	// watch a window for a start pulse
	task automatic waitfor(input int n);
		hit = 1'b0;
		dh = 1'b0;
		repeat (n) begin
			@(negedge sys_clk);
			if (motion.start === 1'b1) hit = 1'b1;
			if (droop_clear === 1'b1) dh = 1'b1;
		end
	endtask
	function automatic logic [11:0] pa(input logic [5:0] n);
		return sssq_pkg::ADR_PBASE + {4'h0, n, 2'b00};
	endfunction
	task automatic home(input logic [31:0] spd, input logic [31:0] adr);
		pin(FS, 1'h1);
		waitfor(8);
		chk("home start", 1'h1, hit);
		chk("home dir", 1'h1, motion.inc_dir);
		chk("home speed", spd, motion.speed);
		pin(NH, 1'h0);
		repeat (6) @(negedge sys_clk);
		chk("creep", 32'h0000_000A, motion.speed);
		pin(HM, 1'h1);
		repeat (6) @(negedge sys_clk);
		chk("homed", 1'h1, homed_out);
		bus(1'h0, sssq_pkg::ADR_CUR, 32'h0000_0000);
		chk("cur addr", adr, q);
		pin(FS, 1'h0);
		pin(NH, 1'h1);
		pin(HM, 1'h0);
	endtask
	initial begin
		n_fail = 0;
		check_count = 0;
		resetn = 1'b0;
		req = 13'h0074;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 12'h000;
		wb_dat_i = 32'h0000_0000;
		wb_sel_i = 4'hF;
		repeat (3) @(posedge sys_clk);
		chk("reset disp", 4'h1, display_code);
		resetn <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			bus(1'h0, pa(pn[k]), 32'h0000_0000);
			chk("param", pv[k], q);
		end
		bus(1'h0, 12'h080, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, q);
		chk("run disp", 4'h1, display_code);
		$display("test params done");
		bus(1'h1, pa(6'h09), 32'h0000_07D0);
		bus(1'h1, pa(6'h2A), 32'h0000_0064);
		bus(1'h0, pa(6'h09), 32'h0000_0000);
		chk("stored", 32'h0000_07D0, q);
		pin(AM, 1'h1);
		pin(EN, 1'h1);
		repeat (4) @(negedge sys_clk);
		chk("locked", 1'h1, servo_locked);
		chk("ready disp", 4'h2, display_code);
		home(32'h0000_03E8, 32'h0000_0000);
		pin(EN, 1'h0);
		bus(1'h1, sssq_pkg::ADR_CTRL, 32'h0000_0001);
		bus(1'h0, sssq_pkg::ADR_CTRL, 32'h0000_0000);
		chk("reload", 32'h0000_0000, q);
		pin(EN, 1'h1);
		repeat (4) @(negedge sys_clk);
		home(32'h0000_07D0, 32'h0000_0064);
		$display("test homing done");
		pin(B0, 1'h1);
		bus(1'h1, sssq_pkg::ADR_PT1, 32'h0000_4E20);
		pin(FS, 1'h1);
		waitfor(8);
		chk("auto start", 1'h1, hit);
		chk("auto pulses", 32'h0004_F999, motion.pulses);
		pin(MD, 1'h1);
		pin(MD, 1'h0);
		waitfor(8);
		chk("held start", 1'h0, hit);
		pin(FS, 1'h0);
		pin(RS, 1'h1);
		waitfor(8);
		chk("rev start", 1'h1, hit);
		pin(FL, 1'h0);
		waitfor(4);
		chk("droop clear", 1'h1, dh);
		pin(RS, 1'h0);
		pin(FL, 1'h0);
		pin(RS, 1'h1);
		waitfor(8);
		chk("limit refuse", 1'h0, hit);
		$display("test auto done");
		pin(FL, 1'h1);
		pin(AL, 1'h1);
		repeat (3) @(negedge sys_clk);
		chk("alarm brake", 1'h1, dyn_brake_on);
		chk("alarm drive", 1'h0, base_drive_on);
		pin(AL, 1'h0);
		pin(ES, 1'h0);
		repeat (3) @(negedge sys_clk);
		chk("estop code", 8'hE6, estop_warning_code);
		pin(ES, 1'h1);
		pin(EN, 1'h0);
		repeat (3) @(negedge sys_clk);
		chk("coast brake", 1'h0, dyn_brake_on);
		chk("coast drive", 1'h0, base_drive_on);
		$display("test stops done");
		conclude();
	end
endmodule
